// ---- design/tld_pkg.sv ----
// Contract
// - Recorder trigger is the OR of all channel triggers.
// - Each channel is either switched off or runs one trigger mode.
// - Every sample yields a value compared against the level: above or below.
// - Crossing logic fires only on a crossing in the configured direction.
// - A sample delay line lets the value be newest minus an older sample.
// - After a crossing, leave the hysteresis band and return before firing again.
// - Two independent comparators with hysteresis: primary and secondary level.
// - Only sampled values are evaluated; nothing between samples is seen.
// - Reaching the level is not enough; the value must pass beyond it.
// - A value equal to the level never fires; first strictly beyond fires.
// - The trigger belongs to the first sample after the crossing.
// - Starting already beyond the level gives no trigger until a real crossing.
// - Basic mode uses the primary comparator with level, direction and hysteresis.
// - Dual mode fires when the value leaves the range through either level.
// - Dual mode with inverted directions fires on re-entering the range.
// - Secondary direction is always the opposite of the primary direction.
// - One hysteresis setting serves both comparators in two-level modes.
// - Window mode: primary level arms and triggers, secondary only disarms.
// - Window mode arms on an opposite-direction primary crossing; unarmed never fires.
// - Armed window fires on a set-direction crossing unless disarmed meanwhile.
package tld_pkg;

  // ==========================================================================
  // Sizes
  localparam int N_CH      = 4;   // Channels in the recorder
  localparam int SW        = 16;  // Sample width, two's complement
  localparam int LW        = 17;  // Level width, covers slope values too
  localparam int HW        = 16;  // Hysteresis width, unsigned
  localparam int CW        = 19;  // Internal compare width, never overflows
  localparam int DLY_DEPTH = 8;   // Older samples held for slope mode
  localparam int DW        = 3;   // Slope distance select, value k means k+1 back
  localparam int FILL_W    = 4;   // Width of the history fill counter

  // ==========================================================================
  // Counts and reset values
  localparam logic [FILL_W-1:0] FILL_MAX  = 4'h9;  // Saturates above deepest need
  localparam logic [FILL_W-1:0] FILL_RST  = 4'h0;
  localparam logic [FILL_W-1:0] FILL_STEP = 4'h1;

  // ==========================================================================
  // Trigger modes
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_BASIC,
    MODE_DUAL,
    MODE_WINDOW
  } tld_mode_t;

endpackage

// ---- design/tld_detector.sv ----
`timescale 1ns/1ps
module tld_detector
(
  input  wire logic                                          core_clk,
  input  wire logic                                          rst,
  input  wire logic                                          rec_start,
  input  wire logic                                          sample_valid,
  input  wire logic [tld_pkg::N_CH-1:0][tld_pkg::SW-1:0]     sample_data,
  input  wire logic [tld_pkg::N_CH-1:0][1:0]                 cfg_mode,
  input  wire logic [tld_pkg::N_CH-1:0]                      cfg_dir_pos,
  input  wire logic [tld_pkg::N_CH-1:0]                      cfg_slope_en,
  input  wire logic [tld_pkg::N_CH-1:0][tld_pkg::DW-1:0]     cfg_slope_dist,
  input  wire logic [tld_pkg::N_CH-1:0][tld_pkg::LW-1:0]     cfg_level_p,
  input  wire logic [tld_pkg::N_CH-1:0][tld_pkg::LW-1:0]     cfg_level_s,
  input  wire logic [tld_pkg::N_CH-1:0][tld_pkg::HW-1:0]     cfg_hyst,
  output logic      [tld_pkg::N_CH-1:0]                      chan_trig,
  output logic                                               rec_trig,
  output logic      [tld_pkg::N_CH-1:0]                      chan_armed
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [tld_pkg::N_CH-1:0][tld_pkg::DLY_DEPTH-1:0][tld_pkg::SW-1:0] hist;
    logic [tld_pkg::N_CH-1:0][tld_pkg::FILL_W-1:0]                      fill;
    logic [tld_pkg::N_CH-1:0]                                           rdy_p;
    logic [tld_pkg::N_CH-1:0]                                           rdy_pa;
    logic [tld_pkg::N_CH-1:0]                                           rdy_s;
    logic [tld_pkg::N_CH-1:0]                                           armed;
    logic [tld_pkg::N_CH-1:0]                                           trig;
    logic                                                               rec_trig;
  } tld_state_t;

  tld_state_t                                       st_q;
  tld_state_t                                       st_d;

  // Per-channel combinational helpers, also watched by the assertions
  logic signed [tld_pkg::N_CH-1:0][tld_pkg::CW-1:0] val_c;
  logic        [tld_pkg::N_CH-1:0][tld_pkg::FILL_W-1:0] need_c;
  logic        [tld_pkg::N_CH-1:0]                  eval_c;
  logic        [tld_pkg::N_CH-1:0]                  prime_c;
  logic        [tld_pkg::N_CH-1:0]                  fire_p_c;
  logic        [tld_pkg::N_CH-1:0]                  fire_s_c;
  logic        [tld_pkg::N_CH-1:0]                  fire_a_c;
  logic        [tld_pkg::N_CH-1:0][1:0]             res_p_c;
  logic        [tld_pkg::N_CH-1:0][1:0]             res_s_c;
  logic        [tld_pkg::N_CH-1:0][1:0]             res_a_c;

  // ==========================================================================
  // Helpers
  // Sign extension of a sample to compare width
  function automatic logic signed [tld_pkg::CW-1:0] sext_smp(
    input logic [tld_pkg::SW-1:0] s
  );
    sext_smp = {{(tld_pkg::CW-tld_pkg::SW){s[tld_pkg::SW-1]}}, s};
  endfunction

  // Sign extension of a level to compare width
  function automatic logic signed [tld_pkg::CW-1:0] sext_lvl(
    input logic [tld_pkg::LW-1:0] l
  );
    sext_lvl = {{(tld_pkg::CW-tld_pkg::LW){l[tld_pkg::LW-1]}}, l};
  endfunction

  // One single-level comparator with hysteresis; returns {fire, ready}.
  // Ready means the value has been outside the band since the last fire.
  function automatic logic [1:0] det_step(
    input logic signed [tld_pkg::CW-1:0] val,
    input logic signed [tld_pkg::CW-1:0] lvl,
    input logic        [tld_pkg::HW-1:0] hyst,
    input logic                          pos,
    input logic                          rdy,
    input logic                          prime
  );
    logic signed [tld_pkg::CW-1:0] hx;
    logic signed [tld_pkg::CW-1:0] arm_pt;
    logic                          beyond;
    logic                          outside;
    logic                          fire;
    hx      = {{(tld_pkg::CW-tld_pkg::HW){1'b0}}, hyst};
    arm_pt  = pos ? (lvl - hx) : (lvl + hx);
    beyond  = pos ? (val > lvl) : (val < lvl);
    outside = pos ? (val < arm_pt) : (val > arm_pt);
    if (prime)
    begin
      // No history yet: only learn which side we are on
      det_step = {1'b0, outside};
    end
    else
    begin
      fire     = rdy & beyond;
      det_step = {fire, outside | (rdy & ~fire)};
    end
  endfunction

  // ==========================================================================
  // Next-state logic for all channels
  always_comb
  begin
    st_d     = st_q;
    val_c    = '0;
    need_c   = '0;
    eval_c   = '0;
    prime_c  = '0;
    fire_p_c = '0;
    fire_s_c = '0;
    fire_a_c = '0;
    res_p_c  = '0;
    res_s_c  = '0;
    res_a_c  = '0;
    st_d.trig = '0;
    for (int c = 0; c < tld_pkg::N_CH; c++)
    begin
      // Value seen by the comparators: level or slope
      val_c[c] = sext_smp(sample_data[c]) -
                 (cfg_slope_en[c] ? sext_smp(st_q.hist[c][cfg_slope_dist[c]])
                                  : '0);
      // Samples needed before the slope value is meaningful
      need_c[c] = cfg_slope_en[c] ? ({1'b0, cfg_slope_dist[c]} + tld_pkg::FILL_STEP)
                                  : tld_pkg::FILL_RST;
      eval_c[c]  = sample_valid && (st_q.fill[c] >= need_c[c]);
      prime_c[c] = st_q.fill[c] == need_c[c];
      res_p_c[c] = det_step(val_c[c], sext_lvl(cfg_level_p[c]), cfg_hyst[c],
                            cfg_dir_pos[c], st_q.rdy_p[c], prime_c[c]);
      // Secondary runs opposite to primary with the same hysteresis
      res_s_c[c] = det_step(val_c[c], sext_lvl(cfg_level_s[c]), cfg_hyst[c],
                            ~cfg_dir_pos[c], st_q.rdy_s[c], prime_c[c]);
      // Primary level watched in the opposite sense, for window arming
      res_a_c[c] = det_step(val_c[c], sext_lvl(cfg_level_p[c]), cfg_hyst[c],
                            ~cfg_dir_pos[c], st_q.rdy_pa[c], prime_c[c]);
      fire_p_c[c] = eval_c[c] & res_p_c[c][1];
      fire_s_c[c] = eval_c[c] & res_s_c[c][1];
      fire_a_c[c] = eval_c[c] & res_a_c[c][1];

      if (rec_start || (cfg_mode[c] == tld_pkg::MODE_OFF))
      begin
        // Disabled or restarted: forget history, prime again later
        st_d.fill[c]   = tld_pkg::FILL_RST;
        st_d.rdy_p[c]  = 1'b0;
        st_d.rdy_s[c]  = 1'b0;
        st_d.rdy_pa[c] = 1'b0;
        st_d.armed[c]  = 1'b0;
      end
      else if (sample_valid)
      begin
        st_d.hist[c] = {st_q.hist[c][tld_pkg::DLY_DEPTH-2:0], sample_data[c]};
        if (st_q.fill[c] != tld_pkg::FILL_MAX)
        begin
          st_d.fill[c] = st_q.fill[c] + tld_pkg::FILL_STEP;
        end
        if (eval_c[c])
        begin
          st_d.rdy_p[c]  = res_p_c[c][0];
          st_d.rdy_s[c]  = res_s_c[c][0];
          st_d.rdy_pa[c] = res_a_c[c][0];
          case (cfg_mode[c])
            tld_pkg::MODE_BASIC:
            begin
              st_d.trig[c] = fire_p_c[c];
            end
            tld_pkg::MODE_DUAL:
            begin
              // Exit or entry depends only on the chosen directions
              st_d.trig[c] = fire_p_c[c] | fire_s_c[c];
            end
            tld_pkg::MODE_WINDOW:
            begin
              // Trigger beats disarm beats arm within one sample
              if (fire_p_c[c] && st_q.armed[c])
              begin
                st_d.trig[c]  = 1'b1;
                st_d.armed[c] = 1'b0;
              end
              else if (fire_s_c[c])
              begin
                st_d.armed[c] = 1'b0;
              end
              else if (fire_a_c[c])
              begin
                st_d.armed[c] = 1'b1;
              end
            end
            default:
            begin
              st_d.trig[c] = 1'b0;
            end
          endcase
        end
      end
    end
    // Registered alongside the channels so both appear on the same edge
    st_d.rec_trig = |st_d.trig;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign chan_trig  = st_q.trig;
  assign rec_trig   = st_q.rec_trig;
  assign chan_armed = st_q.armed;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Beyond-the-level test kept apart from the comparator, so the checks
  // below do not lean on the logic that they guard
  function automatic logic past_lvl(
    input logic signed [tld_pkg::CW-1:0] val,
    input logic        [tld_pkg::LW-1:0] lvl,
    input logic                          pos
  );
    past_lvl = pos ? (val > sext_lvl(lvl)) : (val < sext_lvl(lvl));
  endfunction

  a_rec_trig_or: assert property (rec_trig == (|chan_trig))
    else $error("recorder trigger differs from channel OR");

  for (genvar g = 0; g < tld_pkg::N_CH; g++)
  begin : g_chk
    a_off_is_silent: assert property (
      (cfg_mode[g] == tld_pkg::MODE_OFF) |=> !chan_trig[g])
      else $error("disabled channel triggered");

    a_no_sample_quiet: assert property (
      !sample_valid |=> !chan_trig[g])
      else $error("trigger without a sample");

    a_prime_no_fire: assert property (
      (prime_c[g] && sample_valid) |=> !chan_trig[g])
      else $error("trigger on priming sample");

    a_equal_no_fire: assert property (
      (sample_valid && val_c[g] == sext_lvl(cfg_level_p[g])
       && cfg_mode[g] == tld_pkg::MODE_BASIC) |=> !chan_trig[g])
      else $error("trigger on value equal to level");

    a_basic_fires: assert property (
      (eval_c[g] && !prime_c[g] && !rec_start && st_q.rdy_p[g]
       && cfg_mode[g] == tld_pkg::MODE_BASIC
       && (cfg_dir_pos[g] ? $signed(val_c[g]) > sext_lvl(cfg_level_p[g])
                          : $signed(val_c[g]) < sext_lvl(cfg_level_p[g])))
      |=> chan_trig[g])
      else $error("basic crossing missed");

    a_hyst_rearm: assert property (
      (chan_trig[g] && $past(cfg_mode[g]) == tld_pkg::MODE_BASIC)
      |-> !st_q.rdy_p[g])
      else $error("ready not cleared after trigger");

    a_dual_either: assert property (
      (cfg_mode[g] == tld_pkg::MODE_DUAL && !rec_start
       && (fire_p_c[g] || fire_s_c[g])) |=> chan_trig[g])
      else $error("dual crossing missed");

    a_window_unarmed: assert property (
      (cfg_mode[g] == tld_pkg::MODE_WINDOW && !st_q.armed[g])
      |=> !chan_trig[g])
      else $error("window fired while unarmed");

    a_window_disarm: assert property (
      chan_trig[g] && $past(cfg_mode[g]) == tld_pkg::MODE_WINDOW
      |-> !chan_armed[g] ##1 (!chan_trig[g]))
      else $error("window stayed armed after trigger");

    // Window arming, disarming, firing and restart
    a_arm_needs_cross: assert property (
      (!chan_armed[g] && !fire_a_c[g]) |=> !chan_armed[g])
      else $error("armed without an arming crossing");

    a_disarm_holds: assert property (
      (chan_armed[g] && cfg_mode[g] == tld_pkg::MODE_WINDOW && fire_s_c[g]
       && !fire_p_c[g]) |=> !chan_armed[g])
      else $error("disarm crossing left the channel armed");

    a_window_fires: assert property (
      (chan_armed[g] && cfg_mode[g] == tld_pkg::MODE_WINDOW && fire_p_c[g]
       && !rec_start) |=> chan_trig[g])
      else $error("armed window crossing missed");

    a_start_clears: assert property (
      rec_start |=> (!chan_armed[g] && !chan_trig[g]))
      else $error("restart left state behind");

    a_off_disarms: assert property (
      (cfg_mode[g] == tld_pkg::MODE_OFF) |=> !chan_armed[g])
      else $error("disabled channel still armed");

    a_armed_window_only: assert property (
      (cfg_mode[g] != tld_pkg::MODE_WINDOW && !chan_armed[g]) |=> !chan_armed[g])
      else $error("armed outside window mode");

    // Level checks recomputed from the configured levels
    a_basic_quiet: assert property (
      (cfg_mode[g] == tld_pkg::MODE_BASIC
       && !past_lvl(val_c[g], cfg_level_p[g], cfg_dir_pos[g])) |=> !chan_trig[g])
      else $error("basic trigger without passing the level");

    a_dual_quiet: assert property (
      (cfg_mode[g] == tld_pkg::MODE_DUAL
       && !past_lvl(val_c[g], cfg_level_p[g], cfg_dir_pos[g])
       && !past_lvl(val_c[g], cfg_level_s[g], ~cfg_dir_pos[g])) |=> !chan_trig[g])
      else $error("dual trigger with neither level passed");

    a_dual_low_exit: assert property (
      (cfg_mode[g] == tld_pkg::MODE_DUAL && eval_c[g] && !prime_c[g] && !rec_start
       && st_q.rdy_s[g] && past_lvl(val_c[g], cfg_level_s[g], ~cfg_dir_pos[g]))
      |=> chan_trig[g])
      else $error("secondary crossing missed in dual mode");

    // Shared hysteresis: a secondary fire must clear its own ready
    a_sec_hyst_clear: assert property (
      (chan_trig[g] && $past(fire_s_c[g]) && $past(cfg_mode[g]) == tld_pkg::MODE_DUAL)
      |-> !st_q.rdy_s[g])
      else $error("secondary ready kept after its trigger");

    a_slope_fill_quiet: assert property (
      (cfg_slope_en[g] && st_q.fill[g] <= {1'b0, cfg_slope_dist[g]}) |=> !chan_trig[g])
      else $error("slope trigger before history filled");
  end

  // Covers follow the channel that each mode is exercised on
  c_basic_trig: cover property (
    cfg_mode[0] == tld_pkg::MODE_BASIC ##1 chan_trig[0]);
  c_dual_trig: cover property (
    cfg_mode[1] == tld_pkg::MODE_DUAL && fire_s_c[1] ##1 chan_trig[1]);
  c_reentry_trig: cover property (
    cfg_mode[1] == tld_pkg::MODE_DUAL && !cfg_dir_pos[1] && fire_s_c[1] ##1 chan_trig[1]);
  c_window_trig: cover property (
    chan_armed[2] ##[1:20] (chan_trig[2] && !chan_armed[2]));
  c_slope_trig: cover property (
    cfg_slope_en[2] && cfg_mode[2] == tld_pkg::MODE_BASIC ##1 chan_trig[2]);

endmodule

// ---- tb/tld_adc_model.sv ----
`timescale 1ns/1ps
// ============================================================================
// Sample source standing in for the converter
module tld_adc_model
(
  input  wire logic                                   core_clk,
  output logic                                        sample_valid,
  output logic [tld_pkg::N_CH-1:0][tld_pkg::SW-1:0]   sample_data
);
  // Quiet bus at time zero
  initial
  begin
    sample_valid = 1'b0;
    sample_data  = '0;
  end

  // Idle cycles invert the data so a stale value never looks like a sample
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      sample_valid = 1'b0;
      sample_data  = ~sample_data;
    end
  endtask

  // Gap cycles first, then one sample on channels 0-2 plus noise on channel 3
  task automatic send(input logic [15:0] v, input logic [15:0] r, input int gap);
    idle(gap);
    @(posedge core_clk);
    #1;
    sample_valid = 1'b1;
    sample_data  = {r, v, v, v};
  endtask
endmodule

// ---- tb/sample_level_trigger_detector_test.sv ----
`timescale 1ns/1ps
module sample_level_trigger_detector_test;
  logic                                       core_clk;
  logic                                       rst;
  logic                                       rec_start;
  logic                                       sample_valid;
  logic [tld_pkg::N_CH-1:0][tld_pkg::SW-1:0]  sample_data;
  logic [tld_pkg::N_CH-1:0][1:0]              cfg_mode;
  logic [tld_pkg::N_CH-1:0]                   cfg_dir_pos;
  logic [tld_pkg::N_CH-1:0]                   cfg_slope_en;
  logic [tld_pkg::N_CH-1:0][tld_pkg::DW-1:0]  cfg_slope_dist;
  logic [tld_pkg::N_CH-1:0][tld_pkg::LW-1:0]  cfg_level_p;
  logic [tld_pkg::N_CH-1:0][tld_pkg::LW-1:0]  cfg_level_s;
  logic [tld_pkg::N_CH-1:0][tld_pkg::HW-1:0]  cfg_hyst;
  logic [tld_pkg::N_CH-1:0]                   chan_trig;
  logic                                       rec_trig;
  logic [tld_pkg::N_CH-1:0]                   chan_armed;
  int                                         err_total;
  int                                         checks_done;
  logic [15:0]                                lfsr_q;
  logic [4:0]                                 exp_q[$];
  logic [4:0]                                 e_w;
  logic [15:0]                                seq_v[21];
  logic [4:0]                                 seq_e[21];

  tld_detector tld_detector_inst
  (
    .core_clk       (core_clk),
    .rst            (rst),
    .rec_start      (rec_start),
    .sample_valid   (sample_valid),
    .sample_data    (sample_data),
    .cfg_mode       (cfg_mode),
    .cfg_dir_pos    (cfg_dir_pos),
    .cfg_slope_en   (cfg_slope_en),
    .cfg_slope_dist (cfg_slope_dist),
    .cfg_level_p    (cfg_level_p),
    .cfg_level_s    (cfg_level_s),
    .cfg_hyst       (cfg_hyst),
    .chan_trig      (chan_trig),
    .rec_trig       (rec_trig),
    .chan_armed     (chan_armed)
  );

  tld_adc_model tld_adc_model_inst
  (
    .core_clk     (core_clk),
    .sample_valid (sample_valid),
    .sample_data  (sample_data)
  );

  // ==========================================================================
  // Clock, noise source, compare and verdict
  always #2.5 core_clk = ~core_clk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One compare task per kind of result
  task automatic chk_trig(input logic [3:0] got, input logic [3:0] exp);
    chk({4'h0, got}, {4'h0, exp});
  endtask

  task automatic chk_rec(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask

  task automatic chk_arm(input logic [3:0] got, input logic [3:0] exp);
    chk({4'h0, got}, {4'h0, exp});
  endtask

  task automatic close_out;
    // A note that no sample ever took off the queue counts as a miss
    if (exp_q.size() != 0)
      err_total++;
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Result watcher: one note per accepted sample, result one cycle later
  always @(posedge core_clk)
  begin
    if (sample_valid === 1'b1 && rec_start === 1'b0 && rst === 1'b0)
    begin
      #0.5;
      if (exp_q.size() == 0)
        e_w = 5'h1f;
      else
        e_w = exp_q.pop_front();
      chk_trig(chan_trig, e_w[3:0]);
      chk_rec(rec_trig, |e_w[3:0]);
      chk_arm(chan_armed, {1'b0, e_w[4], 2'b00});
    end
    else if (rst === 1'b0)
    begin
      // No sample taken: the one-cycle pulses must have fallen
      #0.5;
      chk_trig(chan_trig, 4'h0);
      chk_rec(rec_trig, 1'b0);
    end
  end

  // Hang guard, far beyond the roughly 44 cycles the run needs
  initial
  begin
    #2000;
    err_total++;
    close_out();
  end

  // ==========================================================================
  // Stimulus: ch0 basic, ch1 dual, ch2 window, ch3 off with noise
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    rec_start = 1'b0;
    err_total = 0;
    checks_done = 0;
    lfsr_q = 16'h0016;
    cfg_mode = {tld_pkg::MODE_OFF, tld_pkg::MODE_WINDOW, tld_pkg::MODE_DUAL, tld_pkg::MODE_BASIC};
    cfg_dir_pos = 4'h7;
    cfg_slope_en = 4'h0;
    cfg_slope_dist = '0;
    cfg_level_p = {4{17'h00064}};
    cfg_level_s = {17'h00000, 17'h00000, 17'h1ff9c, 17'h00000};
    cfg_hyst = {4{16'h000a}};
    // Start beyond, equal, arm, dip, fire, rearm blocked, dual low exit
    seq_v = '{16'h0096, 16'h0065, 16'h0064, 16'h005f, 16'h0050, 16'h0064, 16'h0065,
              16'h0066, 16'h005f, 16'hff9b, 16'h0065, 16'h0078, 16'h005f, 16'hfffb,
              16'h0065, 16'h0032, 16'h00c8, 16'h0096, 16'hff6a, 16'hffce, 16'h0064};
    // {armed ch2, triggers ch3..ch0}
    seq_e = '{5'h00, 5'h00, 5'h00, 5'h10, 5'h10, 5'h10, 5'h07,
              5'h00, 5'h00, 5'h02, 5'h03, 5'h00, 5'h10, 5'h00,
              5'h03, 5'h00, 5'h00, 5'h00, 5'h03, 5'h06, 5'h00};
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    // Back-to-back samples
    for (int i = 0; i < 15; i++)
    begin
      exp_q.push_back(seq_e[i]);
      lfsr_q = lfsr_next(lfsr_q);
      tld_adc_model_inst.send(seq_v[i], lfsr_q, 0);
    end
    tld_adc_model_inst.idle(3);
    $display("test level modes finished");
    // Restart recording: negative basic, inverted dual, slope on ch2
    @(posedge core_clk);
    #1;
    rec_start = 1'b1;
    cfg_mode[2] = tld_pkg::MODE_BASIC;
    cfg_dir_pos = 4'h4;
    cfg_slope_en = 4'h4;
    cfg_level_p[2] = 17'h00032;
    cfg_hyst[2] = 16'h0000;
    @(posedge core_clk);
    #1;
    rec_start = 1'b0;
    // Slow source with gaps between samples
    for (int i = 15; i < 21; i++)
    begin
      exp_q.push_back(seq_e[i]);
      lfsr_q = lfsr_next(lfsr_q);
      tld_adc_model_inst.send(seq_v[i], lfsr_q, 2);
    end
    tld_adc_model_inst.idle(3);
    $display("test restart and slope finished");
    close_out();
  end
endmodule
